//--- src/spd_pkg.sv
// Shared constants and types for the presence-detect memory slave
package spd_pkg;
   localparam int          CLK_HZ         = 25_000_000;
   localparam logic [3:0]  MEM_PREFIX     = 4'ha;
   localparam logic [3:0]  PROT_PREFIX    = 4'h6;
   localparam int          MEM_ADDR_W     = 8;
   localparam logic [7:0]  LOCK_LIMIT     = 8'h80;
   localparam logic [7:0]  ADDR_RST       = 8'h00;
   localparam longint      WRITE_CYCLE_NS = 64'd5_000_000;
   localparam int          WRITE_CYCLE_CYC =
      int'((WRITE_CYCLE_NS * CLK_HZ) / 64'd1_000_000_000);
   localparam int          BUF_DEPTH      = 2;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_RX    = 3'b001,
      S_RXACK = 3'b010,
      S_TXLD  = 3'b011,
      S_TX    = 3'b100,
      S_TXACK = 3'b101
   } bus_st_t;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_MEM  = 3'b001,
      OP_PERM = 3'b010,
      OP_RLCK = 3'b011,
      OP_RUNL = 3'b100
   } op_t;
endpackage

//--- src/spd_eeprom_protect_and_read.sv
// Two-wire slave: protection instructions and memory reads of a 256-byte store
`timescale 1ns/1ps

// How it works
// - Permanent lock blocks writes to bytes 0-127 forever.
// - Once permanently locked, every 0110b protection access is NACKed, no write cycle.
// - Reversible unlock clears a reversible lock.
// - Lock instructions carry address and data bytes whose contents are ignored.
// - Protected: writes to lower half ACK address bytes, NACK data, no cycle.
// - Ack and write-cycle pattern of lock instructions depends on protection state.
// - Queries use the same framing with read/write bit set.
// - Queries ACK the instruction byte per state; later bytes always NACKed.
// - Address counter points one past last byte accessed, wrapping at end.
// - Read address is ACKed on ninth clock, byte sent MSB first.
// - Dummy write of byte address loads the counter before a read.
// - Each master ACK yields the next byte, counter wrapping.
// - Prefix 1010b plus matching pins selects memory; 0110b selects protection.
// - No slave-address ACK during an internal write cycle.
// - Protection state is held for nonvolatile storage.
module spd_eeprom_protect_and_read
   import spd_pkg::*;
#(
   parameter int MEM_AW = MEM_ADDR_W,     // Memory address width
   parameter int WCYC   = WRITE_CYCLE_CYC // Internal write cycle, clocks
)(
   input  wire logic       clk,            // 25 MHz clock
   input  wire logic       rst_n,          // Sync reset, active low
   input  wire logic       ce,             // Clock enable
   input  wire logic       scl_i,          // Bus clock level
   output wire logic       scl_o,          // Bus clock drive value
   output wire logic       scl_oe,         // Stretch bus clock low
   input  wire logic       sda_i,          // Bus data level
   output wire logic       sda_o,          // Bus data drive value
   output wire logic       sda_oe,         // Pull bus data low
   input  wire logic [2:0] addr_sel,       // Address select pin levels
   input  wire logic       pin_overvoltage_level, // Overvoltage seen on addr_sel_0
   input  wire logic       nv_perm_i,      // Stored permanent lock bit
   input  wire logic       nv_rev_i,       // Stored reversible lock bit
   output logic            nv_perm_o,      // Permanent lock to store
   output logic            nv_rev_o,       // Reversible lock to store
   output wire logic       busy            // Internal write cycle running
);
   localparam int BW = $clog2(WCYC + 1);

   generate
      if (MEM_AW != 8 || WCYC < 1)
      begin : g_bad
         $error("Only 8-bit addressing and a nonzero write cycle are supported");
      end
   endgenerate

   function automatic op_t decode(input logic [6:0] a, input logic [2:0] pins,
                                  input logic ov);
      decode = OP_NONE;
      if (a[6:3] == MEM_PREFIX && a[2:0] == pins) decode = OP_MEM;
      else if (a[6:3] == PROT_PREFIX)
      begin
         if (!ov && a[2:0] == pins) decode = OP_PERM;
         else if (ov && !pins[2] && !a[2] && a[1] == pins[1])
            decode = pins[1] ? OP_RUNL : OP_RLCK;
      end
   endfunction

   logic [7:0]   mem_q [0:255];
   bus_st_t      st_q, st_d;
   logic [2:0]   bitc_q, bitc_d;
   logic [7:0]   sh_q, sh_d;
   logic         ack_q, ack_d, ackph_q, ackph_d, drv_q, drv_d, mack_q, mack_d;
   logic [1:0]   byte_q, byte_d;
   op_t          op_q, op_d;
   logic         rw_q, rw_d, pend_q, pend_d;
   logic [7:0]   waddr_q, waddr_d, wdata_q, wdata_d, addr_q, addr_d;
   logic [BW-1:0] bcnt_q, bcnt_d;
   logic         perm_q, perm_d, rev_q, rev_d, nvld_q;
   logic         scl_q, sda_q, mem_we, flush, pop;
   logic [7:0]   nb;
   op_t          dec_op;
   logic         scl_rise, scl_fall, start_c, stop_c;
   logic [7:0]   buf_q [0:1];
   logic [7:0]   buf_d [0:1];
   logic         wp_q, wp_d, rp_q, rp_d;
   logic [1:0]   cnt_q, cnt_d;
   logic [7:0]   fptr_q, fptr_d;
   logic         push_ready;

   assign scl_rise = scl_i & ~scl_q;
   assign scl_fall = ~scl_i & scl_q;
   assign start_c  = scl_i & scl_q & sda_q & ~sda_i;
   assign stop_c   = scl_i & scl_q & ~sda_q & sda_i;
   assign nb       = {sh_q[6:0], sda_i};
   assign dec_op   = decode(nb[7:1], addr_sel, pin_overvoltage_level);
   assign busy     = (bcnt_q != '0);
   assign sda_o    = 1'b0;
   assign sda_oe   = drv_q;
   assign scl_o    = 1'b0;
   // Stretching only while the buffer is dry keeps slow memories safe
   assign scl_oe   = (st_q == S_TXLD) && (cnt_q == 2'd0);
   assign push_ready = (cnt_q != 2'(BUF_DEPTH));
   assign nv_perm_o  = perm_q;
   assign nv_rev_o   = rev_q;

   always_comb
   begin
      st_d = st_q;  bitc_d = bitc_q;  sh_d = sh_q;  ack_d = ack_q;
      ackph_d = ackph_q;  drv_d = drv_q;  mack_d = mack_q;  byte_d = byte_q;
      op_d = op_q;  rw_d = rw_q;  pend_d = pend_q;  waddr_d = waddr_q;
      wdata_d = wdata_q;  addr_d = addr_q;  perm_d = perm_q;  rev_d = rev_q;
      bcnt_d = busy ? BW'(bcnt_q - 1'b1) : bcnt_q;
      mem_we = 1'b0;  flush = 1'b0;  pop = 1'b0;
      if (nvld_q)
      begin
         perm_d = nv_perm_i;
         rev_d  = nv_rev_i;
      end
      if (start_c)
      begin
         st_d = S_RX;  bitc_d = 3'd0;  byte_d = 2'd0;  drv_d = 1'b0;
         ackph_d = 1'b0;  pend_d = 1'b0;  flush = 1'b1;
      end
      else if (stop_c)
      begin
         st_d = S_IDLE;  drv_d = 1'b0;  pend_d = 1'b0;
         if (pend_q)
         begin
            unique case (op_q)
               OP_MEM:
               begin
                  mem_we = 1'b1;  addr_d = 8'(waddr_q + 8'd1);  flush = 1'b1;
                  bcnt_d = BW'(WCYC);
               end
               OP_PERM:
               begin
                  perm_d = 1'b1;  bcnt_d = BW'(WCYC);
               end
               OP_RLCK:
               begin
                  rev_d = 1'b1;  bcnt_d = BW'(WCYC);
               end
               OP_RUNL:
                  if (rev_q)
                  begin
                     rev_d = 1'b0;  bcnt_d = BW'(WCYC);
                  end
               OP_NONE: ;
            endcase
         end
      end
      else
      begin
         unique case (st_q)
            S_IDLE: ;
            S_RX:
               if (scl_rise)
               begin
                  sh_d = nb;  bitc_d = 3'(bitc_q + 3'd1);
                  if (bitc_q == 3'd7)
                  begin
                     st_d = S_RXACK;  ackph_d = 1'b0;
                     if (byte_q == 2'd0)
                     begin
                        op_d = dec_op;  rw_d = nb[0];
                        // Queries share the lock-state answer of the instructions
                        ack_d = !busy && (dec_op == OP_MEM ||
                                (dec_op != OP_NONE && !perm_q &&
                                 !(rev_q && dec_op == OP_RLCK)));
                     end
                     else if (byte_q == 2'd1)
                     begin
                        ack_d = 1'b1;
                        if (op_q == OP_MEM)
                        begin
                           waddr_d = nb;  addr_d = nb;  flush = 1'b1;
                        end
                     end
                     else if (byte_q == 2'd2 && op_q == OP_MEM)
                     begin
                        // Either lock guards the lower half by the stored byte address
                        ack_d = !((perm_q || rev_q) && waddr_q < LOCK_LIMIT);
                        pend_d = ack_d;
                        wdata_d = nb;
                     end
                     else
                     begin
                        ack_d = (byte_q == 2'd2);
                        pend_d = ack_d;
                     end
                  end
               end
            S_RXACK:
               if (scl_fall)
               begin
                  if (!ackph_q)
                  begin
                     ackph_d = 1'b1;  drv_d = ack_q;
                  end
                  else
                  begin
                     ackph_d = 1'b0;  drv_d = 1'b0;
                     byte_d = (byte_q == 2'd3) ? byte_q : 2'(byte_q + 2'd1);
                     if (!ack_q) st_d = S_IDLE;
                     else if (byte_q == 2'd0 && rw_q)
                        st_d = (op_q == OP_MEM) ? S_TXLD : S_IDLE;
                     else st_d = S_RX;
                  end
               end
            S_TXLD:
               if (cnt_q != 2'd0)
               begin
                  pop = 1'b1;  sh_d = buf_q[rp_q];  drv_d = ~buf_q[rp_q][7];
                  bitc_d = 3'd0;  st_d = S_TX;
                  addr_d = 8'(addr_q + 8'd1);
               end
            S_TX:
               if (scl_fall)
               begin
                  if (bitc_q == 3'd7)
                  begin
                     drv_d = 1'b0;  st_d = S_TXACK;
                  end
                  else
                  begin
                     sh_d = {sh_q[6:0], 1'b0};  drv_d = ~sh_q[6];
                     bitc_d = 3'(bitc_q + 3'd1);
                  end
               end
            S_TXACK:
            begin
               if (scl_rise) mack_d = ~sda_i;
               if (scl_fall) st_d = mack_q ? S_TXLD : S_IDLE;
            end
            default: st_d = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_q <= S_IDLE;  bitc_q <= 3'd0;  sh_q <= 8'h00;  ack_q <= 1'b0;
         ackph_q <= 1'b0;  drv_q <= 1'b0;  mack_q <= 1'b0;  byte_q <= 2'd0;
         op_q <= OP_NONE;  rw_q <= 1'b0;  pend_q <= 1'b0;  waddr_q <= 8'h00;
         wdata_q <= 8'h00;  addr_q <= ADDR_RST;  bcnt_q <= '0;
         perm_q <= 1'b0;  rev_q <= 1'b0;  nvld_q <= 1'b1;
         scl_q <= 1'b1;  sda_q <= 1'b1;
      end
      else if (ce)
      begin
         st_q <= st_d;  bitc_q <= bitc_d;  sh_q <= sh_d;  ack_q <= ack_d;
         ackph_q <= ackph_d;  drv_q <= drv_d;  mack_q <= mack_d;  byte_q <= byte_d;
         op_q <= op_d;  rw_q <= rw_d;  pend_q <= pend_d;  waddr_q <= waddr_d;
         wdata_q <= wdata_d;  addr_q <= addr_d;  bcnt_q <= bcnt_d;
         perm_q <= perm_d;  rev_q <= rev_d;  nvld_q <= 1'b0;
         scl_q <= scl_i;  sda_q <= sda_i;
      end
   end

   always_ff @(posedge clk)
   begin
      if (ce && mem_we) mem_q[waddr_q] <= wdata_q;
   end

   // Prefetch buffer between the array and the shifter
   always_comb
   begin
      buf_d = buf_q;  wp_d = wp_q;  rp_d = rp_q;  cnt_d = cnt_q;  fptr_d = fptr_q;
      if (flush)
      begin
         wp_d = 1'b0;  rp_d = 1'b0;  cnt_d = 2'd0;  fptr_d = addr_d;
      end
      else
      begin
         if (push_ready)
         begin
            buf_d[wp_q] = mem_q[fptr_q];  wp_d = ~wp_q;
            fptr_d = 8'(fptr_q + 8'd1);
         end
         if (pop) rp_d = ~rp_q;
         cnt_d = 2'(cnt_q + {1'b0, push_ready} - {1'b0, pop});
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wp_q <= 1'b0;  rp_q <= 1'b0;  cnt_q <= 2'd0;  fptr_q <= ADDR_RST;
         buf_q[0] <= 8'h00;  buf_q[1] <= 8'h00;
      end
      else if (ce)
      begin
         wp_q <= wp_d;  rp_q <= rp_d;  cnt_q <= cnt_d;  fptr_q <= fptr_d;
         buf_q <= buf_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_rx_decide;
      ce && st_q == S_RX && scl_rise && !start_c && !stop_c && bitc_q == 3'd7;
   endsequence
   sequence s_ack_end;
      ce && st_q == S_RXACK && ackph_q && scl_fall && !start_c && !stop_c;
   endsequence

   chk_perm_sticky: assert property (perm_q && !nvld_q |=> perm_q)
      else $error("permanent lock was lost");
   chk_perm_refuse: assert property (s_rx_decide ##0 (byte_q == 2'd0 && perm_q &&
      dec_op != OP_MEM && dec_op != OP_NONE) |=> !ack_q)
      else $error("protection access acked while permanently locked");
   chk_unlock_clears: assert property (ce && stop_c && pend_q && op_q == OP_RUNL &&
      rev_q |=> !rev_q && busy)
      else $error("reversible unlock did not clear the lock");
   chk_lower_nack: assert property (s_rx_decide ##0 (byte_q == 2'd2 &&
      op_q == OP_MEM && (perm_q || rev_q) && waddr_q < LOCK_LIMIT) |=> !ack_q && !pend_q)
      else $error("protected lower-half data byte acked");
   chk_relock_nack: assert property (s_rx_decide ##0 (byte_q == 2'd0 && rev_q &&
      dec_op == OP_RLCK) |=> !ack_q)
      else $error("reversible lock acked while already locked");
   chk_query_tail: assert property (s_ack_end ##0 (rw_q && op_q != OP_MEM &&
      byte_q == 2'd0) |=> st_q == S_IDLE ##1 !sda_oe)
      else $error("query continued past instruction byte");
   chk_busy_nack: assert property (s_rx_decide ##0 (byte_q == 2'd0 && busy) |=> !ack_q)
      else $error("slave address acked during write cycle");
   chk_load_bit: assert property (ce && st_q == S_TXLD && cnt_q != 2'd0 && !start_c &&
      !stop_c |=> st_q == S_TX && sda_oe == ~sh_q[7] && addr_q == 8'($past(addr_q) + 8'd1))
      else $error("read byte not loaded MSB first");
   chk_sel_load: assert property (s_rx_decide ##0 (byte_q == 2'd1 && op_q == OP_MEM)
      |=> addr_q == waddr_q)
      else $error("byte address not loaded into counter");
endmodule

//--- dv/i2c_master_model.sv
// Two-wire bus master model standing at the slave's far side
`timescale 1ns/1ps
module i2c_master_model (
   input  wire logic       clk,       // Bench clock
   input  wire logic       scl,       // Resolved bus clock
   input  wire logic       sda,       // Resolved bus data
   output logic            scl_pull,  // Pull bus clock low
   output logic            sda_pull,  // Pull bus data low
   output logic            obs_valid, // Result seen, one clock
   output logic [7:0]      obs_val    // Acknowledge bit or read byte
);
   localparam int PH = 4; // Phase length kept above the slave minimum of 3
   initial
   begin
      scl_pull  = 1'b0;
      sda_pull  = 1'b0;
      obs_valid = 1'b0;
      obs_val   = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Slave may stretch the low phase, so wait for the wire itself
   task automatic scl_up();
      int n;
      n = 0;
      scl_pull <= 1'b0;
      tick(1);
      while (scl !== 1'b1 && n < 1000)
      begin
         tick(1);
         n++;
      end
   endtask
   task automatic note(input logic [7:0] v);
      obs_val   <= v;
      obs_valid <= 1'b1;
      tick(1);
      obs_valid <= 1'b0;
   endtask
   task automatic start();
      sda_pull <= 1'b0;
      tick(PH);
      scl_up();
      tick(PH);
      sda_pull <= 1'b1;
      tick(PH);
      scl_pull <= 1'b1;
      tick(PH);
   endtask
   task automatic stop();
      sda_pull <= 1'b1;
      tick(PH);
      scl_up();
      tick(PH);
      sda_pull <= 1'b0;
      tick(PH);
   endtask
   task automatic wbit(input logic b);
      sda_pull <= ~b;
      tick(PH);
      scl_up();
      tick(PH);
      scl_pull <= 1'b1;
      tick(1);
   endtask
   task automatic rbit(output logic b);
      sda_pull <= 1'b0;
      tick(PH);
      scl_up();
      tick(PH / 2);
      b = sda;
      tick(PH / 2);
      scl_pull <= 1'b1;
      tick(1);
   endtask
   task automatic wbyte(input logic [7:0] d);
      logic b;
      for (int i = 7; i >= 0; i--)
         wbit(d[i]);
      rbit(b);
      note({7'h00, ~b});
   endtask
   // Master ends a read with a no-acknowledge before its STOP
   task automatic rbyte(input logic ack);
      logic [7:0] d;
      for (int i = 7; i >= 0; i--)
         rbit(d[i]);
      note(d);
      wbit(~ack);
   endtask
endmodule

//--- dv/testbench.sv
// Self-checking bench for the presence-detect memory slave
`timescale 1ns/1ps
module testbench;
   import spd_pkg::*;
   localparam int         WC   = 400;
   localparam logic [2:0] PINS = 3'b010;
   logic       clk, rst_n, ov, nv_perm_i, nv_rev_i;
   logic [2:0] addr_sel;
   logic [7:0] ptr;
   wire        scl_oe, sda_oe, m_scl, m_sda, obs_valid, nv_perm_o, nv_rev_o, busy;
   wire  [7:0] obs_val;
   wire        scl = ~(scl_oe | m_scl);
   wire        sda = ~(sda_oe | m_sda);
   logic [7:0] exp_q[$];
   logic [7:0] mem_exp[256];
   logic [7:0] wa[4] = '{8'h7f, 8'hfe, 8'hff, 8'h00};
   int         n_mismatch, samples_checked, cycles;
   integer     seed;

   spd_eeprom_protect_and_read #(.WCYC(WC)) dut_u (
      .clk(clk), .rst_n(rst_n), .ce(1'b1), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .addr_sel(addr_sel),
      .pin_overvoltage_level(ov), .nv_perm_i(nv_perm_i), .nv_rev_i(nv_rev_i),
      .nv_perm_o(nv_perm_o), .nv_rev_o(nv_rev_o), .busy(busy));
   i2c_master_model master_u (
      .clk(clk), .scl(scl), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda),
      .obs_valid(obs_valid), .obs_val(obs_val));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (exp_q.size() != 0)
      begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, 8'h00, exp_q.size());
      end
      $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         n_mismatch++;
         stop_test();
      end
      if (obs_valid === 1'b1)
         check(obs_val, exp_q.size() ? exp_q.pop_front() : 8'hxx);
   end
   // Storage outside the device keeps the lock bits across a power cycle
   task automatic power_cycle(input logic keep);
      if (keep)
      begin
         nv_perm_i <= nv_perm_o;
         nv_rev_i  <= nv_rev_o;
      end
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic send(input logic [7:0] b, input logic ack);
      exp_q.push_back({7'h00, ack});
      master_u.wbyte(b);
   endtask
   task automatic after_stop(input logic cyc);
      int n;
      n = 0;
      repeat (4) @(posedge clk);
      check({7'h00, busy}, {7'h00, cyc});
      if (cyc)
      begin
         master_u.start();
         send({MEM_PREFIX, PINS, 1'b1}, 1'b0);
         master_u.stop();
         while (busy === 1'b1 && n < 4 * WC)
         begin
            @(posedge clk);
            n++;
         end
         check({7'h00, busy}, 8'h00);
      end
   endtask
   // kind 0 permanent lock, 1 reversible lock, 2 reversible unlock
   task automatic prot(input int kind, input logic rw, input logic ack, input logic cyc);
      logic [2:0] p;
      p = (kind == 0) ? PINS : {1'b0, kind == 2, 1'b1};
      addr_sel <= p;
      ov       <= (kind != 0);
      @(posedge clk);
      master_u.start();
      send({PROT_PREFIX, p, rw}, ack);
      if (!rw)
         repeat (2) send(8'($random(seed)), ack);
      master_u.stop();
      addr_sel <= PINS;
      ov       <= 1'b0;
      after_stop(cyc);
   endtask
   task automatic mem_write(input logic [7:0] a, input logic [7:0] d, input logic ok);
      master_u.start();
      send({MEM_PREFIX, PINS, 1'b0}, 1'b1);
      send(a, 1'b1);
      send(d, ok);
      master_u.stop();
      if (ok)
         mem_exp[a] = d;
      after_stop(ok);
   endtask
   task automatic mem_read(input logic [7:0] a, input int n, input logic sel);
      master_u.start();
      if (sel)
      begin
         send({MEM_PREFIX, PINS, 1'b0}, 1'b1);
         send(a, 1'b1);
         master_u.start();
         ptr = a;
      end
      send({MEM_PREFIX, PINS, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         exp_q.push_back(mem_exp[ptr]);
         ptr++;
         master_u.rbyte(i < n - 1);
      end
      master_u.stop();
   endtask

   initial
   begin
      seed = 32'h8634ba47;
      {rst_n, ov, nv_perm_i, nv_rev_i} = 4'h0;
      addr_sel = PINS;
      n_mismatch = 0;
      samples_checked = 0;
      cycles = 0;
      power_cycle(1'b0);
      master_u.start();
      send({MEM_PREFIX, ~PINS, 1'b0}, 1'b0);
      master_u.stop();
      foreach (wa[i])
         mem_write(wa[i], 8'($random(seed)), 1'b1);
      mem_read(8'hfe, 2, 1'b1);
      mem_read(8'h00, 1, 1'b0);
      for (int k = 0; k < 3; k++)
         prot(k, 1'b1, 1'b1, 1'b0);
      prot(2, 1'b0, 1'b1, 1'b0);
      prot(1, 1'b0, 1'b1, 1'b1);
      mem_write(8'h7f, 8'($random(seed)), 1'b0);
      mem_write(8'hff, 8'($random(seed)), 1'b1);
      prot(1, 1'b0, 1'b0, 1'b0);
      for (int k = 0; k < 3; k++)
         prot(k, 1'b1, k != 1, 1'b0);
      power_cycle(1'b1);
      check({7'h00, nv_rev_o}, 8'h01);
      mem_write(8'h7f, 8'($random(seed)), 1'b0);
      prot(2, 1'b0, 1'b1, 1'b1);
      check({7'h00, nv_rev_o}, 8'h00);
      mem_write(8'h7f, 8'($random(seed)), 1'b1);
      prot(1, 1'b0, 1'b1, 1'b1);
      prot(0, 1'b0, 1'b1, 1'b1);
      check({7'h00, nv_perm_o}, 8'h01);
      for (int k = 0; k < 3; k++)
      begin
         prot(k, 1'b0, 1'b0, 1'b0);
         prot(k, 1'b1, 1'b0, 1'b0);
      end
      power_cycle(1'b1);
      mem_write(8'h7f, 8'($random(seed)), 1'b0);
      prot(2, 1'b0, 1'b0, 1'b0);
      mem_read(8'h7f, 1, 1'b1);
      stop_test();
   end
endmodule
